//--- verilog/status_indicator.v
// status indication and diagnostic output logic of a contactless safety sensor
// assumes sensor conditions arrive as pins from outside the clock domain
`timescale 1ns/100ps
`include "indicator_map.vh"

// What this block does
// - steady green when both safety inputs live
// - green flashes 1Hz when safety input missing
// - yellow on or flashing with actuator in range, off in error, warning and pause
// - marginal zone: yellow 1Hz, diagnostic pulsed, outputs on
// - red LED active on any error
// - red pulse count encodes error cause
// - teach or internal fault: steady red
// - internal error clears after guard open-close
// - warning: diagnostic low, safety outputs stay on
// - warning clears when cause disappears
// - warning for 30 minutes: outputs off, red flashes
// - no actuator: green only, all outputs low
// - released: yellow only, all outputs high
// - awaiting feedback: green, yellow 1Hz, diagnostic high
// - marginal plus feedback open: yellow alternates 1/5Hz
// - ten minute pause after reteach, green flashing
// - input missing, no actuator: green flashing only
// - input missing, actuator: green flash, yellow, diagnostic
// - error: green off, outputs low, red code
module status_indicator #(
   parameter HALF_1HZ   = `HALF_1HZ_CYC,     // cycles per 1 Hz half period
   parameter HALF_5HZ   = `HALF_5HZ_CYC,     // cycles per 5 Hz half period
   parameter SEC_CYC    = `CLK_HZ,           // cycles per second
   parameter WARN_SEC   = `WARN_TIMEOUT_S,   // warning to shutdown, seconds
   parameter PROTECT_SEC = `PROTECT_PAUSE_S  // protection pause, seconds
) (
   input  wire       clk,
   input  wire       rst,
   input  wire       safety_input_a,             // safety input a live
   input  wire       safety_input_b,             // safety input b live
   input  wire       actuator_present,           // actuator in sensing range
   input  wire       actuator_marginal,          // actuator in marginal zone
   input  wire       feedback_loop,              // feedback loop closed
   input  wire       feedback_falling_edge_mode, // 1: release on falling edge
   input  wire       teach_mode,                 // teach-in running
   input  wire       reteach_done,               // new actuator was taught
   input  wire       internal_fault,             // internal fault present
   input  wire [2:0] error_code,                 // 1..6 error cause, 0 none
   input  wire       warn_temp,                  // overtemperature warning
   input  wire       warn_ext_potential,         // output at external potential
   input  wire       warn_cross,                 // cross circuit warning
   output reg        led_green,
   output reg        led_red,
   output reg        led_yellow,
   output reg        diag_out,                   // diagnostic output, 1 = 24 V
   output reg        safety_output_a,            // 1 = enabled, 24 V
   output reg        safety_output_b
);
   localparam NUM_IN = 15;                       // synchronised input bits
   localparam [31:0] WARN_SPAN = WARN_SEC;
   localparam [31:0] PROT_SPAN = PROTECT_SEC;

   // state codes
   localparam [2:0] ST_IDLE     = 3'h0;          // no actuator
   localparam [2:0] ST_WAIT_FB  = 3'h1;          // actuator, waiting for feedback
   localparam [2:0] ST_RELEASED = 3'h2;          // outputs released
   localparam [2:0] ST_ERROR    = 3'h3;          // latched error
   localparam [2:0] ST_PROTECT  = 3'h4;          // pause after reteach
   localparam [2:0] ST_TEACH    = 3'h5;          // teach mode

   // ---------------- input synchroniser ----------------
   wire [NUM_IN-1:0] raw_in = {safety_input_a, safety_input_b, actuator_present, actuator_marginal,
                               feedback_loop, feedback_falling_edge_mode, teach_mode, reteach_done,
                               internal_fault, error_code, warn_temp, warn_ext_potential, warn_cross};
   reg  [NUM_IN-1:0] sync_a;                     // first stage, read only by sync_b
   reg  [NUM_IN-1:0] sync_b;                     // second stage

   // two flip-flops per bit, one generate loop
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi = gi + 1) begin : g_sync
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= raw_in[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   wire       in_a      = sync_b[14];
   wire       in_b      = sync_b[13];
   wire       act       = sync_b[12];
   wire       marg      = sync_b[11];
   wire       fb        = sync_b[10];
   wire       fb_edge   = sync_b[9];
   wire       teach     = sync_b[8];
   wire       reteach   = sync_b[7];
   wire       int_fault = sync_b[6];
   wire [2:0] code      = sync_b[5:3];
   wire       warn_now  = |sync_b[2:0];          // any warning cause
   wire       inputs_ok = in_a & in_b;
   reg  [2:0] code_d;                            // code one cycle back; its bits may settle apart
   wire       err_now   = int_fault | ((code != 3'h0) && (code == code_d));   // only a settled code counts

   // ---------------- blink and second enables ----------------
   reg [31:0] cnt_1hz;                           // 1 Hz half period counter
   reg [31:0] cnt_5hz;                           // 5 Hz half period counter
   reg [31:0] cnt_sec;                           // one second counter
   reg        blink_1hz;                         // 1 Hz square wave
   reg        blink_5hz;                         // 5 Hz square wave
   reg        tick_5hz;                          // enable every 5 Hz half period
   reg        sec_tick;                          // enable once per second
   reg [2:0]  alt_cnt;                           // 1 Hz halves since rate swap
   reg        alt_fast;                          // alternating rate: 1 = 5 Hz

   // dividers producing one-cycle enables and square waves
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_1hz   <= 32'h0000_0000;
         cnt_5hz   <= 32'h0000_0000;
         cnt_sec   <= 32'h0000_0000;
         blink_1hz <= 1'b0;
         blink_5hz <= 1'b0;
         tick_5hz  <= 1'b0;
         sec_tick  <= 1'b0;
         alt_cnt   <= 3'h0;
         alt_fast  <= 1'b0;
      end else begin
         tick_5hz <= 1'b0;
         sec_tick <= 1'b0;
         // 1 Hz wave also steps the rate alternation
         if (cnt_1hz >= HALF_1HZ - 1) begin
            cnt_1hz   <= 32'h0000_0000;
            blink_1hz <= ~blink_1hz;
            if (alt_cnt >= `ALT_HALVES - 1) begin
               alt_cnt  <= 3'h0;
               alt_fast <= ~alt_fast;
            end else begin
               alt_cnt <= alt_cnt + 3'h1;
            end
         end else begin
            cnt_1hz <= cnt_1hz + 32'h0000_0001;
         end
         // 5 Hz wave and tick for the flash code
         if (cnt_5hz >= HALF_5HZ - 1) begin
            cnt_5hz   <= 32'h0000_0000;
            blink_5hz <= ~blink_5hz;
            tick_5hz  <= 1'b1;
         end else begin
            cnt_5hz <= cnt_5hz + 32'h0000_0001;
         end
         // one second enable for the long timers
         if (cnt_sec >= SEC_CYC - 1) begin
            cnt_sec  <= 32'h0000_0000;
            sec_tick <= 1'b1;
         end else begin
            cnt_sec <= cnt_sec + 32'h0000_0001;
         end
      end
   end

   // ---------------- state machine ----------------
   reg  [2:0] state;                             // operating state
   reg  [2:0] next_state;
   reg  [2:0] err_code;                          // latched flash code, 0 = steady red
   reg        err_cleared;                       // cause gone, waiting for open-close
   reg        guard_opened;                      // guard opened since cause gone
   reg        act_d;                             // actuator delayed for edges
   reg        fb_d;                              // feedback delayed for edges
   reg        warn_active;                       // error warning in effect
   wire       warn_expired;                      // warning lasted the full span
   wire       prot_expired;
   wire       fb_fall   = fb_d & ~fb;
   wire       guard_cyc = guard_opened & act & ~act_d;   // closed again after opening
   wire       release_ok = fb_edge ? fb_fall : fb; // feedback release condition

   // next state decisions
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (act && inputs_ok)
               next_state = ST_WAIT_FB;
         end
         ST_WAIT_FB: begin
            if (!act || !inputs_ok)
               next_state = ST_IDLE;
            else if (release_ok)
               next_state = ST_RELEASED;
         end
         ST_RELEASED: begin
            if (!act || !inputs_ok)
               next_state = ST_IDLE;               // opening disables at once
         end
         ST_ERROR: begin
            if (err_cleared && guard_cyc)
               next_state = ST_IDLE;
         end
         ST_PROTECT: begin
            if (prot_expired && act)
               next_state = ST_IDLE;
         end
         ST_TEACH: begin
            if (!teach)
               next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
      // overriding conditions, teach first, then reteach, then errors
      if (teach)
         next_state = ST_TEACH;
      else if (reteach)
         next_state = ST_PROTECT;
      else if (state != ST_PROTECT && state != ST_ERROR && (err_now || warn_expired))
         next_state = ST_ERROR;
   end

   // state register and error latch
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state        <= ST_IDLE;
         err_code     <= 3'h0;
         err_cleared  <= 1'b0;
         guard_opened <= 1'b0;
         act_d        <= 1'b0;
         fb_d         <= 1'b0;
         code_d       <= 3'h0;
      end else begin
         state <= next_state;
         act_d <= act;
         fb_d  <= fb;
         code_d <= code;
         if (next_state == ST_ERROR && state != ST_ERROR) begin
            // a new error; the warning timeout shows as the temperature code
            err_code     <= int_fault ? 3'h0 : (code != 3'h0 ? code : `CODE_TEMP);
            err_cleared  <= 1'b0;
            guard_opened <= 1'b0;
         end else if (state == ST_ERROR) begin
            err_cleared <= ~err_now;               // cause returns, start over
            if (err_now)
               guard_opened <= 1'b0;
            else if (!act)
               guard_opened <= 1'b1;
         end
      end
   end

   // ---------------- error warning and timers ----------------
   wire       warn_cond = warn_now & (state == ST_RELEASED);   // a warning counts only while released

   // warning follows its cause directly while the outputs are released
   always @(posedge clk or posedge rst) begin
      if (rst)
         warn_active <= 1'b0;
      else
         warn_active <= warn_cond;
   end

   // 30 minute warning timeout; abandoned when the warning clears
   second_timer #(.WIDTH(12)) u_warn_timer (
      .clk      (clk),
      .rst      (rst),
      .load     (warn_cond & ~warn_active),
      .clear    (~warn_active),
      .span     (WARN_SPAN[11:0]),
      .sec_tick (sec_tick),
      .running  (),
      .expired  (warn_expired)
   );

   // 10 minute protection pause, restarted by each reteach
   second_timer #(.WIDTH(12)) u_prot_timer (
      .clk      (clk),
      .rst      (rst),
      .load     (reteach),
      .clear    (1'b0),
      .span     (PROT_SPAN[11:0]),
      .sec_tick (sec_tick),
      .running  (),
      .expired  (prot_expired)
   );

   // ---------------- red flash code sequencer ----------------
   reg [2:0] pulse_num;                          // pulses shown in this group
   reg [3:0] phase_cnt;                          // ticks left in the phase
   reg [1:0] phase;                              // 0 on, 1 gap, 2 pause
   reg       code_led;                           // red flash pattern
   wire [2:0] show_code = (state == ST_ERROR) ? err_code : 3'h0;

   // groups of pulses on the 5 Hz tick, then a long pause
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pulse_num <= 3'h0;
         phase_cnt <= 4'h0;
         phase     <= 2'h2;
         code_led  <= 1'b0;
      end else if (show_code == 3'h0) begin
         pulse_num <= 3'h0;
         phase_cnt <= 4'h0;
         phase     <= 2'h2;
         code_led  <= 1'b0;
      end else if (tick_5hz) begin
         if (phase_cnt != 4'h0) begin
            phase_cnt <= phase_cnt - 4'h1;
         end else begin
            case (phase)
               2'h0: begin                         // pulse ended
                  code_led  <= 1'b0;
                  pulse_num <= pulse_num + 3'h1;
                  if (pulse_num + 3'h1 >= show_code) begin
                     phase     <= 2'h2;
                     phase_cnt <= `CODE_PAUSE_TICKS - 4'h1;
                  end else begin
                     phase     <= 2'h1;
                     phase_cnt <= `CODE_GAP_TICKS - 4'h1;
                  end
               end
               2'h1, 2'h2: begin                   // start a pulse
                  if (phase == 2'h2)
                     pulse_num <= 3'h0;            // new group
                  code_led  <= 1'b1;
                  phase     <= 2'h0;
                  phase_cnt <= `CODE_ON_TICKS - 4'h1;
               end
               default: phase <= 2'h2;
            endcase
         end
      end
   end

   // ---------------- outputs ----------------
   reg next_green, next_red, next_yellow, next_diag, next_safe;

   // indication and output levels per state
   always @* begin
      next_green  = inputs_ok ? 1'b1 : blink_1hz;
      next_red    = 1'b0;
      next_yellow = act;
      next_diag   = 1'b0;
      next_safe   = 1'b0;
      case (state)
         ST_IDLE: begin
            next_diag = act;
         end
         ST_WAIT_FB: begin
            next_green = 1'b1;
            next_diag  = marg ? blink_1hz : 1'b1;
            next_yellow = marg ? (alt_fast ? blink_5hz : blink_1hz) : blink_1hz;
         end
         ST_RELEASED: begin
            next_green = 1'b0;
            next_safe  = 1'b1;
            next_diag  = warn_active ? 1'b0 : (marg ? blink_1hz : 1'b1);
            next_yellow = warn_active ? 1'b0 : (marg ? blink_1hz : 1'b1);
            next_red   = warn_active ? blink_1hz : 1'b0;
         end
         ST_ERROR: begin
            next_green  = 1'b0;
            next_yellow = 1'b0;
            next_red    = (err_code == 3'h0) ? 1'b1 : code_led;
         end
         ST_PROTECT: begin
            next_green  = blink_1hz;
            next_yellow = 1'b0;
         end
         ST_TEACH: begin
            next_green  = 1'b0;
            next_red    = 1'b1;
            next_yellow = blink_1hz;
         end
         default: begin
            next_yellow = 1'b0;
         end
      endcase
   end

   // registered output pins
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         led_green       <= 1'b0;
         led_red         <= 1'b0;
         led_yellow      <= 1'b0;
         diag_out        <= 1'b0;
         safety_output_a <= 1'b0;
         safety_output_b <= 1'b0;
      end else begin
         led_green       <= next_green;
         led_red         <= next_red;
         led_yellow      <= next_yellow;
         diag_out        <= next_diag;
         safety_output_a <= next_safe;
         safety_output_b <= next_safe;
      end
   end
endmodule // status_indicator

//--- verilog/indicator_map.vh
// constants for the safety sensor status indicator: timing counts and flash codes
// assumes a 10 MHz system clock; blink half periods are in clock cycles
`ifndef INDICATOR_MAP_VH
`define INDICATOR_MAP_VH
`define CLK_HZ              10000000
// 1 Hz and 5 Hz blink half periods
`define HALF_1HZ_CYC        (`CLK_HZ / 2)
`define HALF_5HZ_CYC        (`CLK_HZ / 10)
// 1 Hz and 5 Hz alternate every this many 1 Hz half periods
`define ALT_HALVES          4
// flash code: pulse on, gap off, pause between groups (in 5 Hz half periods)
`define CODE_ON_TICKS       4'h2
`define CODE_GAP_TICKS      4'h2
`define CODE_PAUSE_TICKS    4'hA
// long times in seconds
`define WARN_TIMEOUT_S      1800
`define PROTECT_PAUSE_S     600
// flash code numbers
`define CODE_OUT_A          3'h1
`define CODE_OUT_B          3'h2
`define CODE_CROSS          3'h3
`define CODE_TEMP           3'h4
`define CODE_ACTUATOR       3'h5
`define CODE_DISCREPANCY    3'h6
`endif

//--- verilog/second_timer.v
// seconds down-counter: loads a span, counts down on a one-second enable
// assumes sec_tick is a one-cycle pulse on clk
`timescale 1ns/100ps
module second_timer #(
   parameter WIDTH = 12                 // width of the seconds count
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             load,        // start or restart with span
   input  wire             clear,       // abandon the timing
   input  wire [WIDTH-1:0] span,        // seconds to run
   input  wire             sec_tick,    // one-second enable
   output reg              running,     // timing in progress
   output reg              expired      // span elapsed, holds until load or clear
);
   reg [WIDTH-1:0] remain;              // seconds left

   // load wins over clear; the count steps on each second tick
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         remain  <= {WIDTH{1'b0}};
         running <= 1'b0;
         expired <= 1'b0;
      end else if (load) begin
         remain  <= span;
         running <= 1'b1;
         expired <= 1'b0;
      end else if (clear) begin
         running <= 1'b0;
         expired <= 1'b0;
      end else if (running && sec_tick) begin
         // expire on the tick after the count is spent, so a partial first second never cuts the span short
         if (remain == {WIDTH{1'b0}}) begin
            running <= 1'b0;
            expired <= 1'b1;
         end else begin
            remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // second_timer

//--- tb/status_indicator_checker.sv
// concurrent checks on the status indicator ports
// assumes one clock domain, asynchronous active-high reset
`timescale 1ns/100ps
module status_indicator_checker (
   input  wire       clk,
   input  wire       rst,
   input  wire       safety_input_a,
   input  wire       actuator_present,
   input  wire       teach_mode,
   input  wire [2:0] error_code,
   input  wire       warn_temp,
   input  wire       warn_ext_potential,
   input  wire       warn_cross,
   input  wire       led_green,
   input  wire       led_red,
   input  wire       diag_out,
   input  wire       safety_output_a,
   input  wire       safety_output_b
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire warn_any = warn_temp | warn_ext_potential | warn_cross;  // any warning cause

   a_outputs_paired: assert property (safety_output_a == safety_output_b)
      else $error("safety outputs differ");
   a_released_green_off: assert property (safety_output_a |-> !led_green)
      else $error("green lit while released");
   a_no_actuator_off: assert property (!actuator_present [*6] |-> !safety_output_a)
      else $error("outputs on without actuator");
   a_input_lost_off: assert property (!safety_input_a [*6] |-> !safety_output_a)
      else $error("outputs on with input missing");
   a_teach_red_steady: assert property (teach_mode [*6] |-> led_red && !safety_output_a && !diag_out)
      else $error("teach indication wrong");
   a_error_shut_down: assert property ((error_code != 3'h0 && !teach_mode) [*6]
      |-> !safety_output_a && !led_green && !diag_out)
      else $error("error state outputs wrong");
   a_warn_diag_low: assert property (warn_any [*6] ##0 safety_output_a |-> !diag_out)
      else $error("diagnostic high during warning");
   a_released_red_off: assert property ((safety_output_a && diag_out) [*2] |-> !led_red)
      else $error("red lit while released");

   // main scenarios reached
   c_teach: cover property (teach_mode && led_red);
   c_error: cover property (error_code != 3'h0 && !safety_output_a);
   c_warning: cover property (warn_any && safety_output_a && !diag_out);
   c_release: cover property ($rose(safety_output_a));
endmodule // status_indicator_checker

bind status_indicator status_indicator_checker u_chk (.clk(clk), .rst(rst), .safety_input_a(safety_input_a),
   .actuator_present(actuator_present), .teach_mode(teach_mode), .error_code(error_code),
   .warn_temp(warn_temp), .warn_ext_potential(warn_ext_potential), .warn_cross(warn_cross),
   .led_green(led_green), .led_red(led_red), .diag_out(diag_out),
   .safety_output_a(safety_output_a), .safety_output_b(safety_output_b));

//--- tb/plc_partner.sv
// downstream control model: drives the feedback loop and watches the safety outputs
// assumes registered outputs; samples and drives on the rising edge by non-blocking assignment
`timescale 1ns/100ps
module plc_partner (
   input  wire clk,
   input  wire rst,
   input  wire safety_output_a,
   input  wire safety_output_b,
   input  wire fb_close,       // requested loop state
   input  wire fb_slow,        // answer after a delay
   output reg  feedback_loop,  // loop as seen by the sensor
   output int  pair_faults     // cycles with unequal outputs
);
   int wait_cnt;  // delay counter for a slow answer
   // loop follows the request promptly or after six cycles
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         feedback_loop <= 1'b0;
         wait_cnt <= 0;
         pair_faults <= 0;
      end else begin
         if (safety_output_a !== safety_output_b) pair_faults <= pair_faults + 1;
         if (feedback_loop == fb_close) wait_cnt <= 0;
         else if (!fb_slow || wait_cnt >= 5) feedback_loop <= fb_close;
         else wait_cnt <= wait_cnt + 1;
      end
   end
endmodule // plc_partner

//--- tb/safety_sensor_status_indicator_tb.sv
// self-checking bench for the status indicator with shortened timing
// assumes 10 MHz clock; inputs change on the falling edge
`timescale 1ns/100ps
module safety_sensor_status_indicator_tb;
   reg        clk, rst, in_a, in_b, act, marg, fb_mode, teach, reteach, ifault, fb_close, fb_slow;
   reg  [2:0] code;      // error cause
   reg  [2:0] warn;      // cross, potential, temperature
   wire       g, r, y, d, sa, sb, fb;
   int        pf, bad_count, total_checks, n, k, start;

   status_indicator #(.HALF_1HZ(4), .HALF_5HZ(2), .SEC_CYC(10), .WARN_SEC(3), .PROTECT_SEC(3)) u_dut (
      .clk(clk), .rst(rst), .safety_input_a(in_a), .safety_input_b(in_b), .actuator_present(act),
      .actuator_marginal(marg), .feedback_loop(fb), .feedback_falling_edge_mode(fb_mode),
      .teach_mode(teach), .reteach_done(reteach), .internal_fault(ifault), .error_code(code),
      .warn_temp(warn[0]), .warn_ext_potential(warn[1]), .warn_cross(warn[2]),
      .led_green(g), .led_red(r), .led_yellow(y), .diag_out(d), .safety_output_a(sa), .safety_output_b(sb));
   plc_partner u_plc (.clk(clk), .rst(rst), .safety_output_a(sa), .safety_output_b(sb),
      .fb_close(fb_close), .fb_slow(fb_slow), .feedback_loop(fb), .pair_faults(pf));

   // 100 ns clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task end_sim;
      begin
         $display("checks %0d mismatches %0d", total_checks, bad_count);
         if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask

   task check(input logic [7:0] seen, input logic [7:0] exp);
      begin
         total_checks++;
         if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task settle(input int c);
      repeat (c) @(negedge clk);
   endtask

   // model compare: 0/1 steady level, 2 blinking, 3 not checked; order green red yellow diag safety
   task expect_st(input int eg, input int er, input int ey, input int ed, input int es);
      logic [4:0] prev, tog;
      int         ex [5];
      begin
         ex = '{es, ed, ey, er, eg};
         prev = {g, r, y, d, sa};
         tog = 5'h0;
         repeat (16) begin
            @(negedge clk);
            tog = tog | (prev ^ {g, r, y, d, sa});
            prev = {g, r, y, d, sa};
         end
         for (int i = 0; i < 5; i++)
            if (ex[i] == 2) check({7'h0, tog[i]}, 8'h01);
            else if (ex[i] < 2) check({6'h0, tog[i], prev[i]}, 8'(ex[i]));
      end
   endtask

   // counts red pulses between two long pauses
   task count_group(output int cnt);
      int low, started, t;
      begin
         cnt = 0;
         low = 0;
         started = 0;
         for (t = 0; t < 300; t++) begin
            @(negedge clk);
            if (r === 1'b1 && low > 0) begin
               if (low >= 10) begin
                  if (started) break;
                  started = 1;
                  cnt = 0;
               end
               cnt++;
            end
            low = (r === 1'b1) ? 0 : low + 1;
         end
         if (t >= 300) cnt = 0;
      end
   endtask

   // guard opened then closed again
   task reopen;
      begin
         act = 1'b0;
         settle(8 + $urandom_range(0, 3));
         act = 1'b1;
         settle(12);
      end
   endtask

   // bound on the whole run
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_sim;
   end

   initial begin
      {in_a, in_b, act, marg, fb_mode, teach, reteach, ifault, fb_close, fb_slow} = 10'h300;
      code = 3'h0;
      warn = 3'h0;
      rst = 1'b1;
      bad_count = 0;
      total_checks = 0;
      void'($urandom(32'h2346));
      settle(16);
      rst = 1'b0;
      settle(6);
      expect_st(1, 0, 0, 0, 0);
      in_b = 1'b0;
      settle(6);
      expect_st(2, 0, 0, 0, 0);
      act = 1'b1;
      settle(6);
      expect_st(2, 0, 1, 1, 0);
      in_b = 1'b1;
      settle(6);
      expect_st(1, 0, 2, 1, 0);
      marg = 1'b1;
      settle(6);
      expect_st(1, 0, 2, 2, 0);
      marg = 1'b0;
      fb_slow = 1'b1;
      fb_close = 1'b1;
      settle(14);
      expect_st(0, 0, 1, 1, 1);
      marg = 1'b1;
      settle(6);
      expect_st(0, 0, 2, 2, 1);
      marg = 1'b0;
      settle(6);
      in_a = 1'b0;
      settle(6);
      expect_st(2, 0, 1, 1, 0);
      in_a = 1'b1;
      settle(8);
      for (k = 0; k < 3; k++) begin
         warn[k] = 1'b1;
         settle(5);
         expect_st(0, 2, 0, 0, 1);
         warn[k] = 1'b0;
         settle(6);
         expect_st(0, 0, 1, 1, 1);
      end
      warn[0] = 1'b1;
      settle(50);
      check({7'h0, sa}, 8'h00);
      count_group(n);
      check(n[7:0], 8'h04);
      warn[0] = 1'b0;
      reopen;
      start = $urandom_range(0, 5);
      for (k = 0; k < 6; k++) begin
         code = 3'((start + k) % 6 + 1);
         settle(8);
         expect_st(0, 3, 0, 0, 0);
         count_group(n);
         check(n[7:0], {5'h0, code});
         code = 3'h0;
         settle(8);
         check({7'h0, sa}, 8'h00);
         reopen;
         expect_st(0, 0, 1, 1, 1);
      end
      ifault = 1'b1;
      settle(8);
      expect_st(0, 1, 3, 0, 0);
      ifault = 1'b0;
      settle(8);
      check({7'h0, sa}, 8'h00);
      reopen;
      expect_st(0, 0, 1, 1, 1);
      teach = 1'b1;
      settle(8);
      expect_st(0, 1, 2, 0, 0);
      teach = 1'b0;
      reteach = 1'b1;
      settle(3);
      reteach = 1'b0;
      settle(4);
      expect_st(2, 0, 0, 0, 0);
      settle(40);
      expect_st(0, 0, 1, 1, 1);
      fb_mode = 1'b1;
      fb_slow = 1'b0;
      act = 1'b0;
      settle(10);
      act = 1'b1;
      settle(8);
      expect_st(1, 0, 2, 1, 0);
      fb_close = 1'b0;
      settle(8);
      expect_st(0, 0, 1, 1, 1);
      check(pf[7:0], 8'h00);
      end_sim;
   end
endmodule // safety_sensor_status_indicator_tb
